//--- hdl/tws_line_if.sv
// bus line events passed from the line conditioner to the core
`timescale 1ns/1ns
`default_nettype none
interface tws_line_if;
   logic scl_rise;
   logic scl_fall;
   logic sda;
   logic start;
   logic stop;
   logic busy;
   modport det (output scl_rise, output scl_fall, output sda, output start, output stop, output busy);
   modport core (input scl_rise, input scl_fall, input sda, input start, input stop, input busy);
endinterface
`default_nettype wire

//--- hdl/tws_line_sync.sv
// synchroniser and start/stop/edge detector for scl and sda
`timescale 1ns/1ns
`default_nettype none
module tws_line_sync
   import tws_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic scl_in,
   input wire logic sda_in,
   tws_line_if.det ln
);
   typedef struct packed {
      logic [2:0] scl_s;
      logic [2:0] sda_s;
      logic scl;
      logic sda;
      logic scl_rise;
      logic scl_fall;
      logic start;
      logic stop;
      logic busy;
   } tws_sync_t;

   tws_sync_t r_ff;
   tws_sync_t nxt_r;

   always_comb begin
      nxt_r = r_ff;
      nxt_r.scl_s = {r_ff.scl_s[1:0], scl_in};
      nxt_r.sda_s = {r_ff.sda_s[1:0], sda_in};
      // level moves once second and third stage agree
      if (r_ff.scl_s[1] == r_ff.scl_s[2]) begin
         nxt_r.scl = r_ff.scl_s[2];
      end
      if (r_ff.sda_s[1] == r_ff.sda_s[2]) begin
         nxt_r.sda = r_ff.sda_s[2];
      end
      nxt_r.scl_rise = nxt_r.scl & ~r_ff.scl;
      nxt_r.scl_fall = ~nxt_r.scl & r_ff.scl;
      nxt_r.start = r_ff.scl & nxt_r.scl & r_ff.sda & ~nxt_r.sda;
      nxt_r.stop = r_ff.scl & nxt_r.scl & ~r_ff.sda & nxt_r.sda;
      if (nxt_r.start) begin
         nxt_r.busy = 1'b1;
      end else if (nxt_r.stop) begin
         nxt_r.busy = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r_ff <= '{scl_s: 3'h7, sda_s: 3'h7, scl: 1'b1, sda: 1'b1, default: 1'b0};
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign ln.scl_rise = r_ff.scl_rise;
   assign ln.scl_fall = r_ff.scl_fall;
   assign ln.sda = r_ff.sda;
   assign ln.start = r_ff.start;
   assign ln.stop = r_ff.stop;
   assign ln.busy = r_ff.busy;
endmodule // tws_line_sync
`default_nettype wire

//--- hdl/tws_pkg.sv
// constants and enumerations for the two-wire slave receiver
package tws_pkg;
   localparam logic [3:0] TWS_CTRL_OFS = 4'h0;
   localparam logic [3:0] TWS_STAT_OFS = 4'h4;
   localparam logic [3:0] TWS_ADDR_OFS = 4'h8;
   localparam logic [3:0] TWS_DATA_OFS = 4'hC;
   localparam int TWS_FLAG_BIT = 7;
   localparam int TWS_ACKEN_BIT = 6;
   localparam int TWS_BEGIN_BIT = 5;
   localparam int TWS_HALT_BIT = 4;
   localparam int TWS_EN_BIT = 2;
   localparam logic [7:0] TWS_OWN_RST = 8'h00;
   localparam logic [7:0] TWS_DATA_RST = 8'hFF;
   localparam logic [1:0] TWS_PRESC_RST = 2'h0;
   localparam logic [3:0] TWS_BYTE_BITS = 4'h8;
   localparam logic [3:0] TWS_LAST_TX_BIT = 4'h7;
   localparam logic [6:0] TWS_BCAST_ADDR = 7'h00;
   localparam logic [7:0] TWS_ST_NONE = 8'hF8;
   localparam logic [7:0] TWS_ST_SR_OWN = 8'h60;
   localparam logic [7:0] TWS_ST_SR_OWN_ARB = 8'h68;
   localparam logic [7:0] TWS_ST_SR_GC = 8'h70;
   localparam logic [7:0] TWS_ST_SR_GC_ARB = 8'h78;
   localparam logic [7:0] TWS_ST_OWN_ACK = 8'h80;
   localparam logic [7:0] TWS_ST_OWN_NACK = 8'h88;
   localparam logic [7:0] TWS_ST_GC_ACK = 8'h90;
   localparam logic [7:0] TWS_ST_GC_NACK = 8'h98;
   localparam logic [7:0] TWS_ST_ST_OWN = 8'hA8;
   localparam logic [7:0] TWS_ST_ST_ARB = 8'hB0;
   localparam logic [7:0] TWS_ST_TX_ACK = 8'hB8;
   localparam logic [7:0] TWS_ST_TX_NACK = 8'hC0;
   localparam logic [7:0] TWS_ST_TX_LAST = 8'hC8;
   typedef enum logic [2:0] {
      TWS_S_IDLE = 3'b000,
      TWS_S_ADDR = 3'b001,
      TWS_S_AACK = 3'b010,
      TWS_S_HOLD = 3'b011,
      TWS_S_RX = 3'b100,
      TWS_S_RACK = 3'b101,
      TWS_S_TX = 3'b110,
      TWS_S_TACK = 3'b111
   } tws_state_t;
   typedef enum logic [1:0] {
      TWS_M_RX_OWN = 2'b00,
      TWS_M_RX_GC = 2'b01,
      TWS_M_TX = 2'b10
   } tws_mode_t;
endpackage

//--- hdl/tws_slave_rx.sv
// two-wire slave receiver core with apb registers
// Summary of operation
// - last byte sent, master acked: status C8, byte register kept, then unaddressed.
// - unaddressed with acknowledge off: own and broadcast address both ignored.
// - unaddressed with acknowledge on: own address, broadcast only if enabled.
// - begin request on terminal state: unaddressed, start once bus is free.
// - answer own address only when received address equals upper seven address bits.
// - address register bit zero enables answering broadcast address 00.
// - matching address with write bit gives receiver, read bit transmitter.
// - own address plus write sets event flag with valid status.
// - after lost arbitration, addressed write reports 68 own or 78 broadcast.
// - acknowledge cleared mid-transfer gives nack after next received byte.
// - acknowledge off ignores address but keeps watching the bus.
// - in sleep, addressed with acknowledge on: wake part, hold scl until flag cleared.
// - byte register not updated while asleep.
// - own write acked reports 60, broadcast write acked reports 70.
// - in 60 to 78, flag clear receives next byte, ack per acknowledge bit.
// - own-address data byte: 80 on ack, 88 on nack then unaddressed.
// - broadcast data byte: 90 on ack, 98 on nack then unaddressed.
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module tws_slave_rx
   import tws_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [3:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic scl_oe,
   output logic sda_out,
   output logic sda_oe,
   input wire logic sleep_mode,
   input wire logic arb_lost,
   output logic wake_req,
   output logic start_go
);
   typedef struct packed {
      tws_state_t st;
      tws_mode_t mode;
      logic [3:0] cnt;
      logic [7:0] shf;
      logic flag;
      logic ack_en;
      logic begin_req;
      logic halt_req;
      logic unit_en;
      logic [7:0] own;
      logic [7:0] data;
      logic [7:0] code;
      logic [1:0] presc;
      logic last;
      logic term;
      logic arb;
      logic start_pend;
      logic start_go;
      logic wake;
      logic sda_oe;
      logic scl_oe;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } tws_core_t;

   tws_core_t r_ff;
   tws_core_t nxt_r;
   logic wr;
   logic clr;
   logic rel;

   tws_line_if ln ();

   tws_line_sync u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .ln(ln)
   );

   function automatic logic addr_hit(input logic [7:0] own, input logic [7:0] rx);
      logic own_m;
      logic gc_m;
      own_m = (rx[7:1] == own[7:1]);
      gc_m = (rx[7:1] == TWS_BCAST_ADDR) & own[0] & ~rx[0];
      addr_hit = own_m | gc_m;
   endfunction

   function automatic logic reg_sel(input logic [3:0] a, input logic [3:0] ofs);
      reg_sel = (a == ofs);
   endfunction

   assign wr = psel & penable & r_ff.pready & pwrite;
   assign clr = wr & reg_sel(paddr, TWS_CTRL_OFS) & pwdata[TWS_FLAG_BIT];
   assign rel = clr & r_ff.flag;

   always_comb begin
      nxt_r = r_ff;
      nxt_r.start_go = 1'b0;
      // apb: answer in the cycle after setup
      nxt_r.pready = psel & ~penable;
      if (psel & ~penable) begin
         nxt_r.pslverr = 1'b0;
         nxt_r.prdata = 32'h0000_0000;
         if (reg_sel(paddr, TWS_CTRL_OFS)) begin
            nxt_r.prdata[7:0] = {r_ff.flag, r_ff.ack_en, r_ff.begin_req, r_ff.halt_req, 1'b0, r_ff.unit_en, 2'h0};
         end else if (reg_sel(paddr, TWS_STAT_OFS)) begin
            nxt_r.prdata[7:0] = {r_ff.code[7:3], 1'b0, r_ff.presc};
         end else if (reg_sel(paddr, TWS_ADDR_OFS)) begin
            nxt_r.prdata[7:0] = r_ff.own;
         end else if (reg_sel(paddr, TWS_DATA_OFS)) begin
            nxt_r.prdata[7:0] = r_ff.data;
         end else begin
            nxt_r.pslverr = 1'b1;
         end
      end
      if (wr) begin
         if (reg_sel(paddr, TWS_CTRL_OFS)) begin
            nxt_r.ack_en = pwdata[TWS_ACKEN_BIT];
            nxt_r.begin_req = pwdata[TWS_BEGIN_BIT];
            nxt_r.halt_req = pwdata[TWS_HALT_BIT];
            nxt_r.unit_en = pwdata[TWS_EN_BIT];
         end
         if (reg_sel(paddr, TWS_STAT_OFS)) begin
            nxt_r.presc = pwdata[1:0];
         end
         if (reg_sel(paddr, TWS_ADDR_OFS)) begin
            nxt_r.own = pwdata[7:0];
         end
         if (reg_sel(paddr, TWS_DATA_OFS)) begin
            nxt_r.data = pwdata[7:0];
         end
      end
      // flag clear first, so a hardware set below wins
      if (clr) begin
         nxt_r.flag = 1'b0;
      end
      case (r_ff.st)
         TWS_S_IDLE: begin
            nxt_r.sda_oe = 1'b0;
         end
         TWS_S_ADDR: begin
            if (ln.scl_rise) begin
               nxt_r.shf = {r_ff.shf[6:0], ln.sda};
               nxt_r.cnt = r_ff.cnt + 4'h1;
            end else if (ln.scl_fall && r_ff.cnt == TWS_BYTE_BITS) begin
               nxt_r.cnt = 4'h0;
               // acknowledge bit gates matching, bus still watched
               if (r_ff.unit_en & r_ff.ack_en & addr_hit(r_ff.own, r_ff.shf)) begin
                  nxt_r.sda_oe = 1'b1;
                  nxt_r.st = TWS_S_AACK;
                  nxt_r.arb = arb_lost;
                  if (r_ff.shf[0]) begin
                     nxt_r.mode = TWS_M_TX;
                  end else if (r_ff.shf[7:1] == TWS_BCAST_ADDR) begin
                     nxt_r.mode = TWS_M_RX_GC;
                  end else begin
                     nxt_r.mode = TWS_M_RX_OWN;
                  end
               end else begin
                  nxt_r.st = TWS_S_IDLE;
               end
            end
         end
         TWS_S_AACK: begin
            if (ln.scl_fall) begin
               nxt_r.sda_oe = 1'b0;
               nxt_r.flag = 1'b1;
               nxt_r.term = 1'b0;
               nxt_r.st = TWS_S_HOLD;
               case (r_ff.mode)
                  TWS_M_RX_OWN: nxt_r.code = r_ff.arb ? TWS_ST_SR_OWN_ARB : TWS_ST_SR_OWN;
                  TWS_M_RX_GC: nxt_r.code = r_ff.arb ? TWS_ST_SR_GC_ARB : TWS_ST_SR_GC;
                  default: nxt_r.code = r_ff.arb ? TWS_ST_ST_ARB : TWS_ST_ST_OWN;
               endcase
            end
         end
         TWS_S_HOLD: begin
            if (rel) begin
               nxt_r.code = TWS_ST_NONE;
               nxt_r.cnt = 4'h0;
               if (r_ff.term | nxt_r.halt_req) begin
                  nxt_r.st = TWS_S_IDLE;
                  nxt_r.halt_req = 1'b0;
                  if (r_ff.term & nxt_r.begin_req) begin
                     nxt_r.start_pend = 1'b1;
                     nxt_r.begin_req = 1'b0;
                  end
               end else if (r_ff.mode == TWS_M_TX) begin
                  nxt_r.st = TWS_S_TX;
                  nxt_r.shf = r_ff.data;
                  nxt_r.sda_oe = ~r_ff.data[7];
                  nxt_r.last = ~nxt_r.ack_en;
               end else begin
                  nxt_r.st = TWS_S_RX;
               end
            end
         end
         TWS_S_RX: begin
            if (ln.scl_rise) begin
               nxt_r.shf = {r_ff.shf[6:0], ln.sda};
               nxt_r.cnt = r_ff.cnt + 4'h1;
            end else if (ln.scl_fall && r_ff.cnt == TWS_BYTE_BITS) begin
               nxt_r.sda_oe = r_ff.ack_en;
               nxt_r.last = ~r_ff.ack_en;
               if (!sleep_mode) begin
                  nxt_r.data = r_ff.shf;
               end
               nxt_r.st = TWS_S_RACK;
            end
         end
         TWS_S_RACK: begin
            if (ln.scl_fall) begin
               nxt_r.sda_oe = 1'b0;
               nxt_r.flag = 1'b1;
               nxt_r.term = r_ff.last;
               nxt_r.st = TWS_S_HOLD;
               if (r_ff.mode == TWS_M_RX_GC) begin
                  nxt_r.code = r_ff.last ? TWS_ST_GC_NACK : TWS_ST_GC_ACK;
               end else begin
                  nxt_r.code = r_ff.last ? TWS_ST_OWN_NACK : TWS_ST_OWN_ACK;
               end
            end
         end
         TWS_S_TX: begin
            if (ln.scl_fall) begin
               nxt_r.cnt = r_ff.cnt + 4'h1;
               if (r_ff.cnt == TWS_LAST_TX_BIT) begin
                  nxt_r.sda_oe = 1'b0;
                  nxt_r.st = TWS_S_TACK;
               end else begin
                  nxt_r.shf = {r_ff.shf[6:0], 1'b0};
                  nxt_r.sda_oe = ~r_ff.shf[6];
               end
            end
         end
         TWS_S_TACK: begin
            if (ln.scl_rise) begin
               nxt_r.shf[0] = ln.sda;
            end else if (ln.scl_fall) begin
               nxt_r.flag = 1'b1;
               nxt_r.st = TWS_S_HOLD;
               nxt_r.term = r_ff.shf[0] | r_ff.last;
               if (r_ff.shf[0]) begin
                  nxt_r.code = TWS_ST_TX_NACK;
               end else if (r_ff.last) begin
                  nxt_r.code = TWS_ST_TX_LAST;
               end else begin
                  nxt_r.code = TWS_ST_TX_ACK;
               end
            end
         end
         default: begin
            nxt_r.st = TWS_S_IDLE;
         end
      endcase
      // start and stop reset the bit engine except while stretching
      if (r_ff.st != TWS_S_HOLD) begin
         if (ln.start) begin
            nxt_r.st = TWS_S_ADDR;
            nxt_r.cnt = 4'h0;
            nxt_r.shf = 8'h00;
            nxt_r.sda_oe = 1'b0;
         end else if (ln.stop) begin
            nxt_r.st = TWS_S_IDLE;
            nxt_r.sda_oe = 1'b0;
         end
      end
      if (!r_ff.unit_en) begin
         nxt_r.st = TWS_S_IDLE;
         nxt_r.sda_oe = 1'b0;
      end
      if (r_ff.start_pend & ~ln.busy) begin
         nxt_r.start_go = 1'b1;
         nxt_r.start_pend = 1'b0;
      end
      nxt_r.scl_oe = (nxt_r.st == TWS_S_HOLD) & nxt_r.flag;
      nxt_r.wake = sleep_mode & nxt_r.flag & (nxt_r.st == TWS_S_HOLD);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r_ff <= '{st: TWS_S_IDLE, mode: TWS_M_RX_OWN, own: TWS_OWN_RST, data: TWS_DATA_RST,
                   code: TWS_ST_NONE, presc: TWS_PRESC_RST, default: '0};
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign prdata = r_ff.prdata;
   assign pready = r_ff.pready;
   assign pslverr = r_ff.pslverr;
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe = r_ff.scl_oe;
   assign sda_oe = r_ff.sda_oe;
   assign wake_req = r_ff.wake;
   assign start_go = r_ff.start_go;
endmodule // tws_slave_rx
`default_nettype wire

//--- tb/tws_bus_master.sv
// behavioural two-wire bus master
`timescale 1ns/1ns
`default_nettype none
module tws_bus_master (
   input wire logic scl,
   input wire logic sda,
   output logic scl_low,
   output logic sda_low
);
   localparam int Q = 62;
   // sda moves this long after scl falls, never with it
   localparam int H = 2;
   initial begin
      scl_low = 1'h0;
      sda_low = 1'h0;
   end
   task automatic bit_io(input logic b, output logic r);
      #H;
      sda_low = !b;
      #(Q - H);
      scl_low = 1'h0;
      wait (scl === 1'h1);
      r = sda;
      // high phase one longer for a 125 ns bit
      #(Q + 1);
      scl_low = 1'h1;
   endtask
   task automatic start;
      sda_low = 1'h0;
      scl_low = 1'h0;
      wait (scl === 1'h1);
      #Q;
      sda_low = 1'h1;
      #Q;
      scl_low = 1'h1;
   endtask
   task automatic stop;
      #H;
      sda_low = 1'h1;
      #(Q - H);
      scl_low = 1'h0;
      wait (scl === 1'h1);
      #Q;
      sda_low = 1'h0;
      #Q;
   endtask
   // msb first, then ack bit
   task automatic xbyte(input logic [7:0] d, input logic ab, output logic [7:0] q, output logic ak);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
         q[i] = r;
      end
      bit_io(ab, r);
      ak = !r;
   endtask
endmodule // tws_bus_master
`default_nettype wire

//--- tb/tws_slave_rx_props.sv
// port assertions for the two-wire slave receiver
`timescale 1ns/1ns
`default_nettype none
module tws_slave_rx_props
   import tws_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [3:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic scl_out,
   input wire logic scl_oe,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic sleep_mode,
   input wire logic wake_req,
   input wire logic start_go
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire logic clr = psel && penable && pready && pwrite && paddr == TWS_CTRL_OFS && pwdata[7];
   property p_rdy; psel && !penable |=> pready && penable; endproperty
   a_rdy: assert property (p_rdy) else $error("pready late");
   property p_rdy_only; pready |-> psel && penable && $past(psel && !penable); endproperty
   a_rdy_only: assert property (p_rdy_only) else $error("pready outside access");
   property p_err; pready |-> pslverr == (paddr[1:0] != 2'h0); endproperty
   a_err: assert property (p_err) else $error("pslverr wrong");
   property p_rdat; pready |-> prdata[31:8] == 24'h0 && (!pslverr || prdata == 32'h0); endproperty
   a_rdat: assert property (p_rdat) else $error("prdata wrong");
   property p_od; scl_out == 1'h0 && sda_out == 1'h0; endproperty
   a_od: assert property (p_od) else $error("open drain value");
   property p_hold; scl_oe && !clr && !$past(clr) |=> scl_oe; endproperty
   a_hold: assert property (p_hold) else $error("scl let go early");
   property p_rel; scl_oe && clr |-> ##[1:2] !scl_oe; endproperty
   a_rel: assert property (p_rel) else $error("scl not let go");
   property p_ackrel; $rose(scl_oe) |-> !sda_oe; endproperty
   a_ackrel: assert property (p_ackrel) else $error("sda held at stretch");
   property p_wake; wake_req |-> $past(sleep_mode); endproperty
   a_wake: assert property (p_wake) else $error("wake outside sleep");
   property p_go; start_go |=> !start_go; endproperty
   a_go: assert property (p_go) else $error("start pulse too long");
   c_str: cover property ($rose(scl_oe));
   c_wake: cover property (wake_req);
   c_go: cover property (start_go);
   c_err: cover property (pslverr);
endmodule // tws_slave_rx_props
bind tws_slave_rx tws_slave_rx_props u_props (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .scl_out, .scl_oe, .sda_out, .sda_oe, .sleep_mode, .wake_req, .start_go);
`default_nettype wire

//--- tb/tws_slave_rx_tb.sv
// self-checking bench for the two-wire slave receiver
`timescale 1ns/1ns
`default_nettype none
module tws_slave_rx_tb;
   import tws_pkg::*;
   logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic sleep_mode = 1'h0, arb_lost = 1'h0, er, ak;
   logic [3:0] paddr = 4'h0;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, wake_req, start_go, m_scl, m_sda;
   logic [7:0] rb;
   wire logic scl_in = !(scl_oe | m_scl);
   wire logic sda_in = !(sda_oe | m_sda);
   int fail_count = 0, total_checks = 0, cyc = 0, go_cnt = 0;
   localparam logic [31:0] C = 32'hC4, N = 32'h84;
   always #5 clk = ~clk;
   tws_slave_rx dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .scl_in, .sda_in, .scl_out, .scl_oe, .sda_out, .sda_oe, .sleep_mode, .arb_lost,
      .wake_req, .start_go);
   tws_bus_master mst (.scl(scl_in), .sda(sda_in), .scl_low(m_scl), .sda_low(m_sda));
   task automatic wrap_up;
      $display("checks %0d failures %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (start_go === 1'h1) go_cnt++;
      if (cyc == 30000) begin
         fail_count++;
         wrap_up;
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1) @(posedge clk);
      q = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0);
      chk(q, e);
   endtask
   task automatic xb(input logic [7:0] d, input logic ab, input logic ea, input logic [7:0] code);
      mst.xbyte(d, ab, rb, ak);
      chk({31'h0, ak}, {31'h0, ea});
      if (code != 8'h0) begin
         while (scl_oe !== 1'h1) @(posedge clk);
         apb(1'h0, TWS_STAT_OFS, 32'h0);
         chk(q & 32'hF8, {24'h0, code});
      end
   endtask
   logic [7:0] ad[4] = '{8'hAA, 8'h00, 8'hAA, 8'h00};
   logic [7:0] cd[4] = '{8'h60, 8'h70, 8'h68, 8'h78};
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'h1;
      repeat (4) @(posedge clk);
      rd(TWS_STAT_OFS, 32'hF8);
      rd(TWS_ADDR_OFS, 32'h0);
      rd(TWS_DATA_OFS, 32'hFF);
      rd(TWS_CTRL_OFS, 32'h0);
      rd(4'h2, 32'h0);
      chk({31'h0, er}, 32'h1);
      apb(1'h1, TWS_ADDR_OFS, 32'hAB);
      rd(TWS_ADDR_OFS, 32'hAB);
      apb(1'h1, TWS_CTRL_OFS, C);
      $display("test registers done");
      for (int i = 0; i < 4; i++) begin
         @(posedge clk) arb_lost <= i[1];
         mst.start;
         xb(ad[i], 1'h1, 1'h1, cd[i]);
         apb(1'h1, TWS_CTRL_OFS, C);
         xb(8'hA5, 1'h1, 1'h1, cd[i][4] ? 8'h90 : 8'h80);
         rd(TWS_DATA_OFS, 32'hA5);
         apb(1'h1, TWS_CTRL_OFS, N);
         xb(8'h5A, 1'h1, 1'h0, cd[i][4] ? 8'h98 : 8'h88);
         apb(1'h1, TWS_CTRL_OFS, C);
         mst.stop;
      end
      @(posedge clk) arb_lost <= 1'h0;
      $display("test receive codes done");
      apb(1'h1, TWS_ADDR_OFS, 32'hAA);
      mst.start;
      xb(8'h00, 1'h1, 1'h0, 8'h0);
      mst.stop;
      mst.start;
      xb(8'hAC, 1'h1, 1'h0, 8'h0);
      mst.stop;
      $display("test refusals done");
      apb(1'h1, TWS_DATA_OFS, 32'h81);
      mst.start;
      xb(8'hAB, 1'h1, 1'h1, 8'hA8);
      apb(1'h1, TWS_CTRL_OFS, N);
      xb(8'hFF, 1'h0, 1'h1, 8'hC8);
      chk({24'h0, rb}, 32'h81);
      rd(TWS_DATA_OFS, 32'h81);
      apb(1'h1, TWS_CTRL_OFS, N);
      mst.stop;
      mst.start;
      xb(8'hAA, 1'h1, 1'h0, 8'h0);
      mst.stop;
      apb(1'h1, TWS_CTRL_OFS, C);
      mst.start;
      xb(8'hAA, 1'h1, 1'h1, 8'h60);
      apb(1'h1, TWS_CTRL_OFS, N);
      xb(8'h11, 1'h1, 1'h0, 8'h88);
      apb(1'h1, TWS_CTRL_OFS, 32'hE4);
      chk(go_cnt, 32'h0);
      mst.stop;
      repeat (20) @(posedge clk);
      chk(go_cnt, 32'h1);
      $display("test terminal states done");
      @(posedge clk) sleep_mode <= 1'h1;
      mst.start;
      xb(8'hAA, 1'h1, 1'h1, 8'h60);
      repeat (2) @(posedge clk);
      chk({31'h0, wake_req}, 32'h1);
      apb(1'h1, TWS_CTRL_OFS, N);
      xb(8'h77, 1'h1, 1'h0, 8'h88);
      rd(TWS_DATA_OFS, 32'h11);
      apb(1'h1, TWS_CTRL_OFS, C);
      mst.stop;
      @(posedge clk) sleep_mode <= 1'h0;
      $display("test sleep done");
      mst.start;
      xb(8'hAA, 1'h1, 1'h1, 8'h60);
      apb(1'h1, TWS_CTRL_OFS, 32'hD4);
      rd(TWS_CTRL_OFS, 32'h44);
      xb(8'h33, 1'h1, 1'h0, 8'h0);
      mst.stop;
      $display("test halt done");
      wrap_up;
   end
endmodule // tws_slave_rx_tb
`default_nettype wire
